// *** design/sarc_pkg.sv ***
// sarc_pkg: shared constants and types for the converter control link.
// assumes a single 200 MHz clock shared by both ends.
package sarc_pkg;
  localparam int          SARC_CLK_MHZ      = 200;
  localparam int          SARC_CONV_NS      = 3000;
  localparam int          SARC_CONV_CYC     = (SARC_CONV_NS * SARC_CLK_MHZ + 999) / 1000;
  localparam int          SARC_REACQ_NS     = 1000;
  localparam int          SARC_REACQ_CYC    = (SARC_REACQ_NS * SARC_CLK_MHZ + 999) / 1000;
  localparam int          SARC_RES_W        = 12;
  localparam int          SARC_BUS_W        = 12;
  localparam logic [11:0] SARC_RESULT_RST   = 12'h000;
  localparam logic [11:0] SARC_SAMPLE_RST   = 12'h000;
  localparam int          SARC_HI_LO        = 8;
  localparam int          SARC_HI_TOP       = 11;
  localparam int          SARC_ZERO_LO      = 4;
  localparam int          SARC_HOLD_CYC     = 2;
  typedef enum logic [1:0] {
    SARC_MODE_SLOW_PAR,
    SARC_MODE_SLOW_BYTE,
    SARC_MODE_ROM_PAR,
    SARC_MODE_ROM_BYTE
  } sarc_mode_e;
endpackage

// *** design/sarc_if.sv ***
// sarc_if: parallel bus between host and converter control.
// assumes the testbench resolves the data wire from data_oe.
`timescale 1ns/1ps
interface sarc_if;
  logic        chip_select_n;
  logic        read_n;
  logic        byte_select_high;
  logic        busy_n;
  logic [11:0] data_out;
  logic        data_oe;
  modport dev  (input chip_select_n, input read_n, input byte_select_high,
                output busy_n, output data_out, output data_oe);
  modport host (output chip_select_n, output read_n, output byte_select_high,
                input busy_n, input data_out, input data_oe);
endinterface

// *** design/sarc_sync.sv ***
// sarc_sync: three-stage synchroniser, change taken when stages two and three agree.
// assumes the input may come from another clock domain.
`timescale 1ns/1ps
module sarc_sync #(
  parameter int          W   = 3,
  parameter logic [2:0]  RST = 3'h7
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q, s2_q, s3_q;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s1_q <= RST[W-1:0];
      s2_q <= RST[W-1:0];
      s3_q <= RST[W-1:0];
      q_o  <= RST[W-1:0];
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q_o[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// *** design/sarc_dev.sv ***
// sarc_dev: converter control end, start gating, busy, result latch, byte mux.
// assumes control pins may be asynchronous; sample_i is the converter's digital code.
`timescale 1ns/1ps
module sarc_dev
  import sarc_pkg::*;
#(
  parameter int CONV_CYC = sarc_pkg::SARC_CONV_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  sarc_if.dev              bus,
  input  wire logic [11:0] sample_i,
  output logic             conv_done_o
);
  import sarc_pkg::*;

  typedef enum logic {SARC_IDLE, SARC_CONV} sarc_st_e;
  typedef struct packed {
    sarc_st_e    st;
    logic [15:0] cnt;
    logic [11:0] result;
    logic        busy_n;
    logic [11:0] data;
    logic        oe;
    logic        armed;
    logic        done;
  } sarc_dev_s;

  sarc_dev_s   s_q, s_d;
  logic [2:0]  pins;

  // control pins resynchronised; costs up to a few cycles of start lag
  // reset value matches the idle pins (deselected, even address) so no false edge follows reset
  sarc_sync #(.W(3), .RST(3'h6)) u_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    ({bus.chip_select_n, bus.read_n, bus.byte_select_high}),
    .q_o    (pins)
  );

  function automatic logic [11:0] sarc_mux(input logic [11:0] r, input logic hb);
    logic [11:0] v;
    v = r;
    if (hb) begin
      v[SARC_HI_LO-1:SARC_ZERO_LO] = 4'h0;
      v[SARC_ZERO_LO-1:0] = r[SARC_HI_TOP:SARC_HI_LO];
    end
    return v; // top four lines keep the MSBs in every case
  endfunction

  logic sel, start;
  always_comb begin
    sel   = !pins[2] && !pins[1];
    start = sel && !pins[0] && s_q.armed;
    s_d   = s_q;
    s_d.done = 1'b0;
    s_d.oe   = sel;
    s_d.data = sarc_mux(s_q.result, pins[0]);
    if (!sel) begin
      s_d.armed = 1'b1; // one start per read strobe
    end
    case (s_q.st)
      SARC_IDLE: begin
        if (start) begin
          s_d.st     = SARC_CONV;
          s_d.cnt    = 16'(CONV_CYC - 1);
          s_d.busy_n = 1'b0;
          s_d.armed  = 1'b0;
        end
      end
      SARC_CONV: begin
        // new requests are not looked at here
        if (s_q.cnt == 16'h0000) begin
          s_d.st     = SARC_IDLE;
          s_d.result = sample_i;
          s_d.busy_n = 1'b1; // released with the new data on the same edge
          s_d.data   = sarc_mux(sample_i, pins[0]);
          s_d.done   = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end
      default: s_d.st = SARC_IDLE;
    endcase
    // high-byte read never starts, so busy stays high
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_q.st     <= SARC_IDLE;
      s_q.cnt    <= 16'h0000;
      s_q.result <= SARC_RESULT_RST;
      s_q.busy_n <= 1'b1;
      s_q.data   <= 12'h000;
      s_q.oe     <= 1'b0;
      s_q.armed  <= 1'b1;
      s_q.done   <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.busy_n   = s_q.busy_n;
  assign bus.data_out = s_q.data;
  assign bus.data_oe  = s_q.oe;
  assign conv_done_o  = s_q.done;
endmodule

// *** design/sarc_host.sv ***
// sarc_host: host end, issues reads in the chosen mode and returns a result word.
// assumes the device shares clk_i, so no resynchronisation of busy_n is needed.
`timescale 1ns/1ps
module sarc_host
  import sarc_pkg::*;
#(
  parameter int CONV_CYC  = sarc_pkg::SARC_CONV_CYC,
  parameter int REACQ_CYC = sarc_pkg::SARC_REACQ_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  sarc_if.host             bus,
  input  wire sarc_pkg::sarc_mode_e mode_i,
  input  wire logic        req_i,
  output logic             ready_o,
  output logic             ack_o,
  output logic [11:0]      result_o
);
  import sarc_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_ASSERT, H_WAIT, H_HOLD, H_GAP} sarc_hst_e;
  typedef struct packed {
    sarc_hst_e   st;
    logic        cs_n;
    logic        rd_n;
    logic        hb;
    logic [15:0] cnt;
    logic [11:0] acc;
    logic        ack;
    logic [11:0] res;
    logic        rdy;
  } sarc_host_s;

  sarc_host_s h_q, h_d;
  logic       slow, byt;

  always_comb begin
    slow = (mode_i == SARC_MODE_SLOW_PAR) || (mode_i == SARC_MODE_SLOW_BYTE);
    byt  = (mode_i == SARC_MODE_SLOW_BYTE) || (mode_i == SARC_MODE_ROM_BYTE);
    h_d  = h_q;
    h_d.ack = 1'b0;
    case (h_q.st)
      H_IDLE: begin
        h_d.rdy = 1'b1;
        if (req_i) begin
          h_d.rdy    = 1'b0;
          h_d.hb     = 1'b0; // even address: start or low byte
          h_d.st     = H_ASSERT;
        end
      end
      H_ASSERT: begin
        h_d.cs_n = 1'b0;
        h_d.rd_n = 1'b0;
        h_d.cnt  = 16'(SARC_HOLD_CYC + 4);
        h_d.st   = H_WAIT;
      end
      H_WAIT: begin
        // wait for busy to show, then for it to rise in slow mode
        if (h_q.cnt != 16'h0000) begin
          h_d.cnt = h_q.cnt - 16'h0001;
        end else if (!slow || h_q.hb || bus.busy_n) begin
          h_d.st = H_HOLD;
        end
      end
      H_HOLD: begin
        h_d.cs_n = 1'b1;
        h_d.rd_n = 1'b1;
        if (h_q.hb) begin
          h_d.acc[11:8] = bus.data_out[3:0];
        end else if (byt) begin
          h_d.acc[7:0] = bus.data_out[7:0];
        end else begin
          h_d.acc = bus.data_out;
        end
        h_d.st = H_GAP;
        if (slow || !byt) begin
          // ROM parallel spacing covers conversion plus reacquisition; slow modes wait reacquisition only
          h_d.cnt = slow ? 16'(REACQ_CYC) : 16'(CONV_CYC + REACQ_CYC);
        end else begin
          h_d.cnt = 16'(CONV_CYC);
        end
      end
      H_GAP: begin
        if (h_q.cnt != 16'h0000) begin
          h_d.cnt = h_q.cnt - 16'h0001;
        end else if (byt && !h_q.hb) begin
          h_d.hb = 1'b1; // odd address reads the high byte
          h_d.st = H_ASSERT;
        end else begin
          h_d.ack = 1'b1;
          h_d.res = h_q.acc;
          h_d.hb  = 1'b0;
          h_d.st  = H_IDLE;
        end
      end
      default: h_d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      h_q.st     <= H_IDLE;
      h_q.cs_n   <= 1'b1;
      h_q.rd_n   <= 1'b1;
      h_q.hb     <= 1'b0;
      h_q.cnt    <= 16'h0000;
      h_q.acc    <= 12'h000;
      h_q.ack    <= 1'b0;
      h_q.res    <= 12'h000;
      h_q.rdy    <= 1'b0;
    end else begin
      h_q <= h_d;
    end
  end

  assign bus.chip_select_n    = h_q.cs_n;
  assign bus.read_n           = h_q.rd_n;
  assign bus.byte_select_high = h_q.hb;
  assign ready_o  = h_q.rdy;
  assign ack_o    = h_q.ack;
  assign result_o = h_q.res;
endmodule

// *** testbench/sarc_monitor.sv ***
// sarc_monitor: timing checks on the host-device bus.
// assumes one shared clock and a synchronous active-low reset.
`timescale 1ns/1ps
module sarc_monitor #(
  parameter int CONV_CYC = sarc_pkg::SARC_CONV_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        chip_select_n,
  input  wire logic        read_n,
  input  wire logic        byte_select_high,
  input  wire logic        busy_n,
  input  wire logic [11:0] data_out,
  input  wire logic        data_oe
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // counts busy-low cycles; 16 bits covers the full-length conversion too
  logic [15:0] low_q;
  logic [15:0] low_d;
  always_comb low_d = busy_n ? 16'h0000 : low_q + 16'h0001;
  always_ff @(posedge clk_i) low_q <= nrst_i ? low_d : 16'h0000;
  sequence s_sel;
    !chip_select_n && !read_n;
  endsequence
  sequence s_start;
    s_sel ##0 !byte_select_high;
  endsequence
  sequence s_hi_read;
    s_sel ##0 byte_select_high;
  endsequence
  a_reset_idle: assert property (disable iff (1'b0) !nrst_i |=>
    busy_n && !data_oe && data_out == 12'h000) else $error("outputs not idle in reset");
  a_busy_length: assert property ($rose(busy_n) |-> low_q == CONV_CYC)
    else $error("busy low length wrong");
  a_start_gate: assert property ($fell(busy_n) |-> s_start)
    else $error("conversion began without start strobes");
  a_hi_no_start: assert property (s_hi_read |-> busy_n)
    else $error("busy low during high-byte read");
  a_oe_rise: assert property ($rose(data_oe) |-> s_sel)
    else $error("data driven without select and read");
  a_oe_fall: assert property ($fell(data_oe) |-> chip_select_n || read_n)
    else $error("data released while still selected");
  a_hi_format: assert property (data_oe && byte_select_high && $past(byte_select_high, 5)
    |-> data_out[7:4] == 4'h0 && data_out[3:0] == data_out[11:8])
    else $error("high-byte bus pattern wrong");
  a_old_held: assert property (!busy_n && $past(!busy_n) |-> $stable(data_out))
    else $error("result changed during conversion");
endmodule

// *** testbench/sarc_tb.sv ***
// sarc_tb: host and device ends joined, random transfers in all four modes.
// assumes shortened counts: 20-cycle conversion, 8-cycle reacquisition.
`timescale 1ns/1ps
module sarc_tb;
  import sarc_pkg::*;
  localparam int CONV  = 20;
  localparam int REACQ = 8;
  logic        clk_i    = 1'b0;
  logic        nrst_i   = 1'b0;
  sarc_mode_e  mode_i   = SARC_MODE_SLOW_PAR;
  logic        req_i    = 1'b0;
  logic [11:0] sample_i = 12'h000;
  logic        ready_o;
  logic        ack_o;
  logic        conv_done_o;
  logic [11:0] result_o;
  logic [11:0] latch_w  = 12'h000;
  logic [11:0] rnd      = 12'h054;
  int          fail_count = 0;
  int          checked    = 0;
  int          dones      = 0;
  sarc_if bus_if ();
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (conv_done_o === 1'b1) dones++;
  sarc_dev #(.CONV_CYC(CONV)) sarc_dev_inst (.clk_i(clk_i), .nrst_i(nrst_i), .bus(bus_if),
    .sample_i(sample_i), .conv_done_o(conv_done_o));
  sarc_host #(.CONV_CYC(CONV), .REACQ_CYC(REACQ)) sarc_host_inst (.clk_i(clk_i),
    .nrst_i(nrst_i), .bus(bus_if), .mode_i(mode_i), .req_i(req_i), .ready_o(ready_o),
    .ack_o(ack_o), .result_o(result_o));
  sarc_monitor #(.CONV_CYC(CONV)) sarc_monitor_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .chip_select_n(bus_if.chip_select_n), .read_n(bus_if.read_n),
    .byte_select_high(bus_if.byte_select_high), .busy_n(bus_if.busy_n),
    .data_out(bus_if.data_out), .data_oe(bus_if.data_oe));
  function automatic logic [11:0] lfsr(input logic [11:0] s);
    return {s[10:0], s[11] ^ s[10] ^ s[9] ^ s[3]};
  endfunction
  // rom parallel reads hand back the latch as it stood before this start; rom byte reads pair the old low byte with the new high byte
  function automatic logic [11:0] expect_word(input sarc_mode_e m, input logic [11:0] old_w,
                                              input logic [11:0] new_w);
    case (m)
      SARC_MODE_ROM_PAR:  return old_w;
      SARC_MODE_ROM_BYTE: return {new_w[11:8], old_w[7:0]};
      default:            return new_w;
    endcase
  endfunction
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input sarc_mode_e m, input logic [11:0] s);
    int n = 0;
    @(posedge clk_i);
    #1;
    while (ready_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    mode_i   = m;
    sample_i = s;
    req_i    = 1'b1;
    @(posedge clk_i);
    #1;
    req_i = 1'b0;
    while (ack_o !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (ack_o !== 1'b1) begin
      fail_count++;
      $display("[ERR] ack expected 1 seen %b", ack_o);
    end
    chk("result", expect_word(m, latch_w, s), result_o);
    latch_w = s;
  endtask
  task automatic summarize();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    // rom modes first so the first result shows the cleared latch
    for (int i = 0; i < 4; i++) begin
      xfer(sarc_mode_e'((i + 2) % 4), 12'hFFF);
      xfer(sarc_mode_e'((i + 2) % 4), 12'h000);
      for (int k = 0; k < 4; k++) begin
        rnd = lfsr(rnd);
        xfer(sarc_mode_e'((i + 2) % 4), rnd);
      end
      $display("test mode %0d done", (i + 2) % 4);
    end
    chk("conversions", 12'(checked), 12'(dones));
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    $display("[ERR] watchdog expected finish seen hang");
    summarize();
  end
endmodule
